// *** gpp_pkg.sv ***
// package: register map, pin roles and carrier types of the general-purpose pin port
package gpp_pkg;

	// ==========================================
	// register offsets, both access paths
	localparam logic       SPACE_WIN     = 1'b0;   // device-control memory window
	localparam logic       SPACE_CFG     = 1'b1;   // legacy configuration space
	localparam logic [7:0] OFS_WIN_DIR   = 8'h40;
	localparam logic [7:0] OFS_WIN_LEVEL = 8'h42;
	localparam logic [7:0] OFS_CFG_DIR   = 8'hB4;
	localparam logic [7:0] OFS_CFG_LEVEL = 8'hB6;

	// ==========================================
	// reset values and reserved read value
	localparam logic [7:0]  DIR_RESET   = 8'h00;
	localparam logic [7:0]  LEVEL_RESET = 8'h00;
	localparam logic [7:0]  RSVD_READ   = 8'h00;
	localparam logic [15:0] RDATA_RESET = 16'h0000;

	// ==========================================
	// pins carrying a secondary function
	localparam int         PIN_CLKRUN   = 0;
	localparam int         PIN_POWER    = 1;
	localparam int         PIN_SCL      = 4;
	localparam int         PIN_SDA      = 5;
	localparam logic [7:0] SEC_PIN_MASK = 8'h33;
	localparam int         SYNC_STAGES  = 2;

	// ==========================================
	// carriers
	typedef struct packed {
		logic        space;   // SPACE_WIN or SPACE_CFG
		logic [7:0]  addr;    // byte offset
		logic        rd;      // read strobe, one cycle
		logic        wr;      // write strobe, one cycle
		logic [1:0]  be;      // byte lanes of wdata
		logic [15:0] wdata;
	} gpp_req_t;

	typedef struct packed {
		logic clkrun_en;
		logic clkrun_out;
		logic clkrun_oe;
		logic power_override_en;
		logic power_override_out;
		logic power_override_oe;
		logic serial_bus_enable;
		logic serial_clock_out;
		logic serial_clock_oe;
		logic serial_data_out;
		logic serial_data_oe;
	} gpp_func_t;

	typedef struct packed {
		logic [7:0]  dir;
		logic [7:0]  level;
		logic [7:0]  pin_out;
		logic [7:0]  pin_oe;
		logic [15:0] rd_data;
		logic        rd_valid;
	} gpp_state_t;

endpackage : gpp_pkg

// *** gpp_sync.sv ***
// two-stage synchroniser for a bus of independent levels
`timescale 1ns/100ps
module gpp_sync #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	import gpp_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} gpp_sync_state_t;

	gpp_sync_state_t sync_reg;
	gpp_sync_state_t sync_next;

	// ==========================================
	// first stage feeds only the second
	always_comb
	begin
		sync_next    = sync_reg;
		sync_next.s1 = d;
		sync_next.s2 = sync_reg.s1;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			sync_reg <= '0;
		else
			sync_reg <= sync_next;
	end

	assign q = sync_reg.s2;

endmodule : gpp_sync

// *** gpp_port.sv ***
// general-purpose pin port: direction and level registers with pin muxing
//
// Operation
// - each of the eight pins has a direction bit, 0 input and 1 output, all inputs by default.
// - a pin enabled for its secondary function ignores the direction bit entirely.
// - pins 0, 1, 4 and 5 carry clock-run, power override, serial clock and serial data.
// - reading the level register returns the sampled level of every input-mode pin.
// - writing a level bit of an output-mode pin changes the level driven on that pin.
// - writes to level bits of input-mode or secondary-function pins are discarded.
// - bits 15 to 8 of both registers ignore writes and read as zero.
// - link reset, global reset and power-on reset return both registers to defaults.
// - after power-up the level register low byte reflects sampled pins since all are inputs.
// - the window copies and the configuration copies are one and the same storage.
// - the serial-bus enable decides whether pins 4 and 5 are general pins or serial lines.
`timescale 1ns/100ps
module gpp_port (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              link_reset_b,
	input  wire logic              global_reset_input_b,
	input  wire gpp_pkg::gpp_req_t  req,
	output logic       [15:0]      rd_data,
	output logic                   rd_valid,
	input  wire gpp_pkg::gpp_func_t func,
	input  wire logic  [7:0]       pin_in,
	output logic       [7:0]       pin_out,
	output logic       [7:0]       pin_oe,
	output logic       [7:0]       pin_level_sync
);
	import gpp_pkg::*;

	gpp_state_t state_reg;
	gpp_state_t state_next;
	logic [7:0] pin_sync;
	logic [1:0] rst_sync;
	logic       soft_rst;
	logic [7:0] sec_en;
	logic [7:0] sec_out;
	logic [7:0] sec_oe;
	logic [7:0] out_mask;
	logic [7:0] level_view;
	logic       hit_dir;
	logic       hit_level;
	logic       wr_lo;

	// ==========================================
	// synchronisers for pins and reset inputs
	gpp_sync #(
		.W (8)
	) u_pin_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.d     (pin_in),
		.q     (pin_sync)
	);

	gpp_sync #(
		.W (2)
	) u_rst_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.d     ({link_reset_b, global_reset_input_b}),
		.q     (rst_sync)
	);

	// either reset input clears the registers
	assign soft_rst = !rst_sync[1] || !rst_sync[0];

	// ==========================================
	// secondary function routing
	always_comb
	begin
		sec_en              = 8'h00;
		sec_out             = 8'h00;
		sec_oe              = 8'h00;
		sec_en[PIN_CLKRUN]  = func.clkrun_en;
		sec_out[PIN_CLKRUN] = func.clkrun_out;
		sec_oe[PIN_CLKRUN]  = func.clkrun_oe;
		sec_en[PIN_POWER]   = func.power_override_en;
		sec_out[PIN_POWER]  = func.power_override_out;
		sec_oe[PIN_POWER]   = func.power_override_oe;
		sec_en[PIN_SCL]     = func.serial_bus_enable;
		sec_out[PIN_SCL]    = func.serial_clock_out;
		sec_oe[PIN_SCL]     = func.serial_clock_oe;
		sec_en[PIN_SDA]     = func.serial_bus_enable;
		sec_out[PIN_SDA]    = func.serial_data_out;
		sec_oe[PIN_SDA]     = func.serial_data_oe;
	end

	// general pins in output mode; only these accept level writes
	assign out_mask   = state_reg.dir & ~sec_en;
	// output pins read back driven value, all others the sampled pin
	assign level_view = (out_mask & state_reg.level) | (~out_mask & pin_sync);

	// ==========================================
	// address decode, one storage for both paths
	assign hit_dir   = (req.space == SPACE_WIN && req.addr == OFS_WIN_DIR)
		|| (req.space == SPACE_CFG && req.addr == OFS_CFG_DIR);
	assign hit_level = (req.space == SPACE_WIN && req.addr == OFS_WIN_LEVEL)
		|| (req.space == SPACE_CFG && req.addr == OFS_CFG_LEVEL);
	assign wr_lo     = req.wr && req.be[0];                          // upper lane is reserved

	// ==========================================
	// next state: writes, reads, resets, pin drive
	always_comb
	begin
		state_next          = state_reg;
		state_next.rd_valid = 1'b0;
		if (wr_lo && hit_dir)
			state_next.dir = req.wdata[7:0];
		if (wr_lo && hit_level)
			state_next.level = (state_reg.level & ~out_mask)
				| (req.wdata[7:0] & out_mask);
		if (req.rd)
		begin
			state_next.rd_valid = 1'b1;
			if (hit_dir)
				state_next.rd_data = {RSVD_READ, state_reg.dir};
			else if (hit_level)
				state_next.rd_data = {RSVD_READ, level_view};
			else
				state_next.rd_data = RDATA_RESET;                     // unmapped reads zero
		end
		if (soft_rst)
		begin
			state_next.dir   = DIR_RESET;
			state_next.level = LEVEL_RESET;
		end
		// secondary function owns its pin, else direction and level
		state_next.pin_oe  = (sec_en & sec_oe)
			| (state_next.dir & ~sec_en);
		state_next.pin_out = (sec_en & sec_out)
			| (state_next.dir & ~sec_en & state_next.level);
	end

	// state register, cleared asynchronously only by power-on reset
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg         <= '0;
			state_reg.dir     <= DIR_RESET;
			state_reg.level   <= LEVEL_RESET;
			state_reg.rd_data <= RDATA_RESET;
		end
		else
			state_reg <= state_next;
	end

	// outputs straight from flip-flops
	assign rd_data        = state_reg.rd_data;
	assign rd_valid       = state_reg.rd_valid;
	assign pin_out        = state_reg.pin_out;
	assign pin_oe         = state_reg.pin_oe;
	assign pin_level_sync = pin_sync;

	// ==========================================
	// assertions
	AST_RESET_DEFAULTS: assert property (@(posedge clk) disable iff (!rst_b)
		soft_rst |=> (state_reg.dir == DIR_RESET) && (state_reg.level == LEVEL_RESET))
		else $error("registers not at defaults after reset input");

	AST_INPUT_NOT_DRIVEN: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> ((pin_oe & ~$past(sec_en)) == (state_reg.dir & ~$past(sec_en))))
		else $error("general pin enable does not follow direction");

	AST_SEC_OWNS_PIN: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> ((pin_oe & $past(sec_en)) == ($past(sec_oe) & $past(sec_en)))
			&& ((pin_out & $past(sec_en)) == ($past(sec_out) & $past(sec_en))))
		else $error("secondary function pin not driven by its function");

	AST_SEC_PIN_MAP: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> ((pin_oe & ~SEC_PIN_MASK) == (state_reg.dir & ~SEC_PIN_MASK)))
		else $error("secondary function on a plain pin");

	AST_CLKRUN_PIN: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> (pin_out[PIN_CLKRUN] == ($past(func.clkrun_en) ? $past(func.clkrun_out)
			: (state_reg.dir[PIN_CLKRUN] && state_reg.level[PIN_CLKRUN]))))
		else $error("clock-run pin not owned by its function");

	AST_READ_INPUT: assert property (@(posedge clk) disable iff (!rst_b)
		(req.rd && hit_level) |=> rd_valid
			&& ((rd_data[7:0] & ~$past(out_mask)) == ($past(pin_sync) & ~$past(out_mask))))
		else $error("level read does not show sampled input");

	AST_WRITE_DRIVES: assert property (@(posedge clk) disable iff (!rst_b)
		(wr_lo && hit_level && !soft_rst) |=>
			((pin_out & $past(out_mask)) == ($past(req.wdata[7:0]) & $past(out_mask))))
		else $error("output pin not driven to written level");

	AST_WRITE_DISCARD: assert property (@(posedge clk) disable iff (!rst_b)
		(wr_lo && hit_level && !soft_rst) |=>
			((state_reg.level & ~$past(out_mask)) == ($past(state_reg.level) & ~$past(out_mask))))
		else $error("write to input or secondary pin was kept");

	AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
		rd_valid |-> (rd_data[15:8] == RSVD_READ))
		else $error("reserved upper byte not zero");

	AST_ALIAS_DIR: assert property (@(posedge clk) disable iff (!rst_b)
		(wr_lo && hit_dir && !soft_rst) ##1 (!req.wr && !soft_rst)
			##1 (req.rd && hit_dir && !req.wr) |=>
			(rd_data[7:0] == $past(req.wdata[7:0], 3)))
		else $error("direction copies disagree between paths");

	AST_RESET_INPUTS_FREE: assert property (@(posedge clk) disable iff (!rst_b)
		soft_rst |=> ((pin_oe & ~$past(sec_en)) == 8'h00))
		else $error("general pin still driven after reset input");

	AST_SERIAL_ENABLE_PAIR: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> (pin_oe[PIN_SCL] == ($past(func.serial_bus_enable)
			? $past(func.serial_clock_oe) : state_reg.dir[PIN_SCL]))
			&& (pin_oe[PIN_SDA] == ($past(func.serial_bus_enable)
			? $past(func.serial_data_oe) : state_reg.dir[PIN_SDA])))
		else $error("serial pins do not follow the serial-bus enable");

	AST_READ_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> (rd_valid == $past(req.rd)))
		else $error("read answer not one cycle after the read");

	AST_DIR_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
		(wr_lo && hit_dir && !soft_rst) |=> (state_reg.dir == $past(req.wdata[7:0])))
		else $error("direction write not stored");

endmodule : gpp_port

// *** gpp_board.sv ***
// board model: drives the eight general-purpose pins wherever the port does not
`timescale 1ns/100ps
module gpp_board (
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] ext_level,
	output logic      [7:0] pin_in
);
	// ==========================================
	// wire level: the port's drive wins, the board level elsewhere
	assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : gpp_board

// *** test_gpp_port.sv ***
// self-checking test of the general-purpose pin port
`timescale 1ns/100ps
module test_gpp_port;
	import gpp_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        link_reset_b = 1'b1;
	logic        global_reset_input_b = 1'b1;
	gpp_req_t    req = '0;
	gpp_func_t   func = '0;
	logic [7:0]  ext_level = 8'hA5;
	logic [7:0]  pin_in;
	logic [15:0] rd_data;
	logic        rd_valid;
	logic [7:0]  pin_out;
	logic [7:0]  pin_oe;
	logic [7:0]  level_sync;
	int          n_fail = 0;
	int          checks_done = 0;

	// ==========================================
	// clock, design and board
	always #25 clk = ~clk;
	gpp_port u_dut (.clk(clk), .rst_b(rst_b), .link_reset_b(link_reset_b),
		.global_reset_input_b(global_reset_input_b), .req(req), .rd_data(rd_data),
		.rd_valid(rd_valid), .func(func), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_level_sync(level_sync));
	gpp_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
		.pin_in(pin_in));

	// ==========================================
	// access and compare tasks
	task stop_test;
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task wr(input logic sp, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{sp, a, 1'b0, 1'b1, 2'b11, d};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : wr
	task rd(input logic sp, input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		req <= '{sp, a, 1'b1, 1'b0, 2'b00, 16'h0000};
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		chk({15'h0000, rd_valid}, 16'h0001);
		chk(rd_data, exp);
	endtask : rd
	// driven value compared only where the pin is driven
	task pins(input logic [7:0] eo, input logic [7:0] eoe);
		cyc(1);
		#1;
		chk({pin_out & pin_oe, pin_oe}, {eo, eoe});
	endtask : pins

	// ==========================================
	// test sequence
	initial
	begin
		cyc(5);
		rst_b <= 1'b1;
		cyc(5);
		rd(SPACE_WIN, OFS_WIN_DIR, 16'h0000);
		rd(SPACE_CFG, OFS_CFG_LEVEL, 16'h00A5);
		wr(SPACE_WIN, OFS_WIN_DIR, 16'hFFFF);
		rd(SPACE_CFG, OFS_CFG_DIR, 16'h00FF);
		wr(SPACE_CFG, OFS_CFG_LEVEL, 16'hFFC3);
		pins(8'hC3, 8'hFF);
		rd(SPACE_WIN, OFS_WIN_LEVEL, 16'h00C3);
		wr(SPACE_WIN, OFS_WIN_DIR, 16'h000F);
		ext_level <= 8'h5A;
		wr(SPACE_WIN, OFS_WIN_LEVEL, 16'h003C);
		cyc(3);
		#1;
		chk({8'h00, level_sync}, 16'h005C);
		rd(SPACE_WIN, OFS_WIN_LEVEL, 16'h005C);
		wr(SPACE_WIN, OFS_WIN_DIR, 16'h00FF);
		pins(8'hCC, 8'hFF);
		// clock-run, power override and serial functions take pins 0, 1, 4, 5
		cyc(1);
		func <= 11'h5DC;
		pins(8'hDC, 8'hDD);
		wr(SPACE_WIN, OFS_WIN_LEVEL, 16'h0033);
		func <= 11'h000;
		pins(8'h00, 8'hFF);
		// link reset, global reset, then power-on reset in mid-run
		for (int k = 0; k < 3; k++)
		begin
			wr(SPACE_WIN, OFS_WIN_DIR, 16'h00FF);
			if (k == 0)
				link_reset_b <= 1'b0;
			else if (k == 1)
				global_reset_input_b <= 1'b0;
			else
				rst_b <= 1'b0;
			cyc(1);
			link_reset_b <= 1'b1;
			global_reset_input_b <= 1'b1;
			rst_b <= 1'b1;
			cyc(4);
			rd(SPACE_WIN, OFS_WIN_DIR, 16'h0000);
			pins(8'h00, 8'h00);
		end
		// write on the upper lane only must leave the direction alone
		@(posedge clk);
		req <= '{SPACE_WIN, OFS_WIN_DIR, 1'b0, 1'b1, 2'b10, 16'h00FF};
		@(posedge clk);
		req.wr <= 1'b0;
		rd(SPACE_WIN, OFS_WIN_DIR, 16'h0000);
		rd(SPACE_WIN, 8'h44, 16'h0000);
		stop_test;
	end

	// watchdog against a hang
	initial
	begin
		#100000;
		n_fail++;
		stop_test;
	end
endmodule : test_gpp_port
